//--- shared/mtc_pkg.sv
/*
 * mtc_pkg: constants and carrier types for the five-channel timer counters.
 * Assumes a register port with word index addressing and 16-bit data.
 */
package mtc_pkg;

	localparam int CHANNELS = 5;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 4;

	// register indices, one per channel counter, then control words
	localparam logic [3:0] REG_CNT0 = 4'h0;
	localparam logic [3:0] REG_CTRL = 4'h5;
	localparam logic [3:0] REG_DIRECTION = 4'h6;

	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;

	// control register fields
	localparam int CTRL_RUN_LSB = 0;
	localparam int CTRL_CLEAR_LSB = 5;
	localparam int CTRL_PHASE_BIT = 10;
	localparam int CTRL_CASCADE_BIT = 11;
	localparam int CTRL_CPWM_BIT = 12;

	typedef enum logic [1:0] {
		MTC_DIR_UP = 2'b00,
		MTC_DIR_DOWN = 2'b01
	} mtc_dir_t;

	typedef struct packed {
		logic                wr;
		logic                rd;
		logic [ADDR_W-1:0]   addr;
		logic [CNT_W-1:0]    wdata;
	} mtc_req_t;

	// packed from the top bit down: bit 12 first, run field in bits 4:0
	typedef struct packed {
		logic                cpwm_mode;
		logic                cascade_mode;
		logic                phase_mode;
		logic [CHANNELS-1:0] clear_on_match;
		logic [CHANNELS-1:0] run;
	} mtc_ctrl_t;

endpackage

//--- rtl/mtc_channel.sv
/*
 * mtc_channel: one 16-bit channel counter with compare-match clearing.
 * Assumes count_en and count_down come from logic on the same clock.
 */
`timescale 1ns/1ps
module mtc_channel #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	// control
	input  wire logic             hold_zero_i,
	input  wire logic             count_en_i,
	input  wire logic             count_down_i,
	input  wire logic             clear_on_match_i,
	input  wire logic [WIDTH-1:0] compare_i,
	// software write
	input  wire logic             wr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	// state
	output logic      [WIDTH-1:0] count_o,
	output logic                  match_o
);

	assign match_o = (count_o == compare_i);

	// clear happens on the count edge leaving the matching state
	always_ff @(posedge clock_i)
	begin
		if (rst_i || hold_zero_i)
			count_o <= mtc_pkg::CNT_RESET;
		else if (wr_i)
			count_o <= wdata_i;
		else if (count_en_i && clear_on_match_i && match_o)
			count_o <= mtc_pkg::CNT_RESET;
		else if (count_en_i && count_down_i)
			count_o <= count_o - mtc_pkg::CNT_ONE;
		else if (count_en_i)
			count_o <= count_o + mtc_pkg::CNT_ONE;
	end

endmodule // mtc_channel

//--- rtl/mtc_counters.sv
/*
 * mtc_counters: five 16-bit channel counters of a multifunction timer unit.
 * Assumes a one-cycle strobe register port and the peripheral clock.
 */
// The implementer's own choices: the plain strobed port and the register offsets.
// What this block does
// - five channel counters, one per timer channel, each sixteen bits wide
// - power-on reset and standby force every channel counter to zero
// - manual reset leaves every channel counter unchanged
// - channels 1 and 2 count down only in phase or cascade mode
// - channels 3 and 4 count down only in complementary PWM mode
// - compare-match clear happens in the last state equal to compare
// - with compare N an up-counting channel's count period spans N+1 states
// - with clear on match and counting up, the count period rate is the tick_i rate divided by compare value plus one
`timescale 1ns/1ps
module mtc_counters #(
	parameter int CHANNELS = mtc_pkg::CHANNELS,
	parameter int WIDTH = mtc_pkg::CNT_W
) (
	// clock and resets
	input  wire logic                      clock_i,
	input  wire logic                      rst_i,
	input  wire logic                      manual_rst_i,
	input  wire logic                      standby_i,
	// register port
	input  wire logic [mtc_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [WIDTH-1:0]          wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	output logic      [WIDTH-1:0]          rdata_o,
	// compare values and count ticks from the mode logic
	input  wire logic [CHANNELS*WIDTH-1:0] compare_i,
	input  wire logic [CHANNELS-1:0]       tick_i,
	input  wire logic [CHANNELS-1:0]       down_req_i,
	// state
	output logic      [CHANNELS-1:0]       match_o,
	output logic      [CHANNELS-1:0]       down_o
);

	////////////////////////////////////////////////////////////////////////
	mtc_pkg::mtc_req_t  req;
	mtc_pkg::mtc_ctrl_t ctrl;
	logic [WIDTH-1:0]            count [CHANNELS];
	logic [CHANNELS-1:0]         match;
	logic [CHANNELS-1:0]         dir_down;
	logic [CHANNELS-1:0]         count_en;
	logic [CHANNELS-1:0]         wr_ch;
	logic [WIDTH-1:0]            next_rdata;

	assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

	////////////////////////////////////////////////////////////////////////
	// control register; manual reset leaves it and counters alone
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			ctrl <= '0;
		else if (req.wr && req.addr == mtc_pkg::REG_CTRL)
			ctrl <= req.wdata[mtc_pkg::CTRL_CPWM_BIT:0];
	end

	////////////////////////////////////////////////////////////////////////
	// direction per channel
	always_comb
	begin
		dir_down = '0;
		dir_down[0] = 1'b0;
		dir_down[1] = down_req_i[1] && (ctrl.phase_mode || ctrl.cascade_mode);
		dir_down[2] = down_req_i[2] && (ctrl.phase_mode || ctrl.cascade_mode);
		dir_down[3] = down_req_i[3] && ctrl.cpwm_mode;
		dir_down[4] = down_req_i[4] && ctrl.cpwm_mode;
	end

	////////////////////////////////////////////////////////////////////////
	// five counters
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : g_ch
			assign count_en[g] = ctrl.run[g] && tick_i[g];
			assign wr_ch[g] = req.wr &&
				(req.addr == mtc_pkg::REG_CNT0 + 4'(g));
			mtc_channel #(
				.WIDTH(WIDTH)
			) u_ch (
				.clock_i         (clock_i),
				.rst_i           (rst_i),
				.hold_zero_i     (standby_i),
				.count_en_i      (count_en[g]),
				.count_down_i    (dir_down[g]),
				.clear_on_match_i(ctrl.clear_on_match[g]),
				.compare_i       (compare_i[g*WIDTH +: WIDTH]),
				.wr_i            (wr_ch[g]),
				.wdata_i         (req.wdata),
				.count_o         (count[g]),
				.match_o         (match[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// read mux, data one cycle after strobe
	always_comb
	begin
		next_rdata = '0;
		if (req.addr < mtc_pkg::REG_CTRL)
			next_rdata = count[req.addr[2:0]];
		else if (req.addr == mtc_pkg::REG_CTRL)
			next_rdata = WIDTH'(ctrl);
		else if (req.addr == mtc_pkg::REG_DIRECTION)
			next_rdata = WIDTH'(dir_down);
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			rdata_o <= '0;
		else if (req.rd)
			rdata_o <= next_rdata;
		else
			rdata_o <= '0;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			match_o <= '0;
			down_o <= '0;
		end
		else
		begin
			match_o <= match;
			down_o <= dir_down;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_zero_on_standby;
		@(posedge clock_i) disable iff (rst_i)
		standby_i |=> (count[0] == '0 && count[4] == '0);
	endproperty
	a_zero_on_standby: assert property (p_zero_on_standby)
		else $error("counter not zero in standby");

	property p_zero_after_reset;
		@(posedge clock_i) $rose(rst_i) |=> (count[1] == '0);
	endproperty
	a_zero_after_reset: assert property (p_zero_after_reset)
		else $error("counter not cleared by reset");

	property p_manual_holds;
		@(posedge clock_i) disable iff (rst_i)
		(manual_rst_i && !standby_i && !count_en[2] && !wr_ch[2])
			|=> $stable(count[2]);
	endproperty
	a_manual_holds: assert property (p_manual_holds)
		else $error("manual reset changed counter");

	property p_ch0_up;
		@(posedge clock_i) disable iff (rst_i)
		(count_en[0] && !standby_i && !wr_ch[0] && !(ctrl.clear_on_match[0]
			&& match[0])) |=> count[0] == $past(count[0]) + 16'h0001;
	endproperty
	a_ch0_up: assert property (p_ch0_up)
		else $error("channel 0 did not count up");

	property p_ch1_dir;
		@(posedge clock_i) disable iff (rst_i)
		dir_down[1] |-> (ctrl.phase_mode || ctrl.cascade_mode);
	endproperty
	a_ch1_dir: assert property (p_ch1_dir)
		else $error("channel 1 down outside phase or cascade");

	property p_ch3_dir;
		@(posedge clock_i) disable iff (rst_i)
		(dir_down[3] || dir_down[4]) |-> ctrl.cpwm_mode;
	endproperty
	a_ch3_dir: assert property (p_ch3_dir)
		else $error("channel 3 or 4 down outside complementary mode");

	property p_match_clear;
		@(posedge clock_i) disable iff (rst_i)
		(count_en[2] && ctrl.clear_on_match[2] && match[2] && !wr_ch[2]
			&& !standby_i) |=> count[2] == '0;
	endproperty
	a_match_clear: assert property (p_match_clear)
		else $error("no clear after compare match");

	property p_read_once;
		@(posedge clock_i) disable iff (rst_i)
		!req.rd |=> rdata_o == '0;
	endproperty
	a_read_once: assert property (p_read_once)
		else $error("read data outside read cycle");

	c_clear: cover property (@(posedge clock_i) disable iff (rst_i)
		count_en[2] && ctrl.clear_on_match[2] && match[2]);
	c_down: cover property (@(posedge clock_i) disable iff (rst_i)
		count_en[3] && dir_down[3]);
	c_standby: cover property (@(posedge clock_i) disable iff (rst_i)
		standby_i);

endmodule // mtc_counters

//--- sim/mtc_counters_bench.sv
/*
 * mtc_counters_bench: self-checking bench for the five channel counters.
 * Assumes mtc_pkg and mtc_counters compiled before it; drives all ports.
 */
`timescale 1ns/1ps
module mtc_counters_bench;
	logic        clock_i = 0;
	logic        rst_i = 1;
	logic        manual_rst_i = 0;
	logic        standby_i = 0;
	logic [3:0]  addr_i = 0;
	logic [15:0] wdata_i = 0;
	logic        wr_i = 0;
	logic        rd_i = 0;
	logic [15:0] rdata_o;
	logic [79:0] compare_i = {80{1'b1}};
	logic [4:0]  tick_i = 0;
	logic [4:0]  down_req_i = 0;
	logic [4:0]  match_o;
	logic [4:0]  down_o;
	int          num_errors = 0;
	int          check_count = 0;
	int          cyc = 0;
	logic [35:0] rows [6] = '{{4'h0, 16'hA5A5, 16'hA5A5},
		{4'h1, 16'hFFFF, 16'hFFFF}, {4'h2, 16'h0001, 16'h0001},
		{4'h3, 16'h8000, 16'h8000}, {4'h4, 16'h1234, 16'h1234},
		{4'h7, 16'hBEEF, 16'h0000}};
	logic [15:0] modes [4] = '{16'h001F, 16'h041F, 16'h081F, 16'h101F};
	logic [4:0]  dirs [4] = '{5'h00, 5'h06, 5'h06, 5'h18};

	always #50 clock_i = ~clock_i;

	mtc_counters u_dut (.clock_i(clock_i), .rst_i(rst_i),
		.manual_rst_i(manual_rst_i), .standby_i(standby_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .compare_i(compare_i), .tick_i(tick_i),
		.down_req_i(down_req_i), .match_o(match_o), .down_o(down_o));

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock_i);
		wr_i <= 1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clock_i);
		rd_i <= 1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 0;
		#1;
		check($sformatf("reg%0d", a), rdata_o, exp);
	endtask

	// ticks held for n cycles, pulse rules kept upstream
	task automatic tk(input logic [4:0] m, input int n);
		@(posedge clock_i);
		tick_i <= m;
		repeat (n) @(posedge clock_i);
		tick_i <= 0;
	endtask

	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			num_errors++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (3) @(posedge clock_i);
		rst_i <= 0;
		for (int i = 0; i < 5; i++) rd(i[3:0], 16'h0000);
		rd(4'h6, 16'h0000);
		$display("test reset done");
		foreach (rows[i])
		begin
			wr(rows[i][35:32], rows[i][31:16]);
			rd(rows[i][35:32], rows[i][15:0]);
		end
		$display("test access done");
		down_req_i <= 5'h1F;
		foreach (modes[i])
		begin
			wr(4'h5, modes[i]);
			repeat (2) @(posedge clock_i);
			#1;
			check("direction", {11'h0, down_o}, {11'h0, dirs[i]});
		end
		$display("test direction done");
		wr(4'h5, 16'h041F);
		tk(5'h1F, 1);
		rd(4'h0, 16'hA5A6);
		rd(4'h1, 16'hFFFE);
		rd(4'h3, 16'h8001);
		wr(4'h5, 16'h101F);
		tk(5'h1F, 1);
		rd(4'h1, 16'hFFFF);
		rd(4'h3, 16'h8000);
		$display("test count done");
		wr(4'h2, 16'h0000);
		compare_i[32+:16] <= 16'h0003;
		wr(4'h5, 16'h009F);
		tk(5'h04, 3);
		rd(4'h2, 16'h0003);
		check("match2", {15'h0, match_o[2]}, 16'h0001);
		tk(5'h04, 1);
		rd(4'h2, 16'h0000);
		tk(5'h04, 4);
		rd(4'h2, 16'h0000);
		$display("test compare done");
		manual_rst_i <= 1;
		repeat (2) @(posedge clock_i);
		manual_rst_i <= 0;
		rd(4'h4, 16'h1234);
		standby_i <= 1;
		wr(4'h4, 16'h5555);
		standby_i <= 0;
		rd(4'h4, 16'h0000);
		wr(4'h0, 16'h7777);
		rst_i <= 1;
		@(posedge clock_i);
		rst_i <= 0;
		rd(4'h0, 16'h0000);
		$display("test resets done");
		print_verdict();
	end
endmodule // mtc_counters_bench
